/* File: tx_line_coding_defines.svh */
// Timing, width and seed constants for the twisted-pair line coding block
`ifndef TX_LINE_CODING_DEFINES_SVH
`define TX_LINE_CODING_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and Manchester timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define MAN_BIT_NS        100
`define MAN_HALF_CYC      ((`MAN_BIT_NS / 2) / `CLK_PERIOD_NS)
`define MAN_BIT_CYC       (`MAN_BIT_NS / `CLK_PERIOD_NS)
`define MAN_EDGE_GAP_CYC  ((`MAN_BIT_CYC * 3) / 4)
`define MAN_IDLE_CYC      (`MAN_BIT_CYC * 2)
`define MAN_CNT_W         6

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define NIBBLE_W          4
`define NIB_LAST_BIT      2'h3
`define ADDR_W            5

// ----------------------------------------------------------------------
// Stream cipher
// ----------------------------------------------------------------------
`define CIPHER_W          11
`define CIPHER_TAP_A      10
`define CIPHER_TAP_B      8
`define CIPHER_RESET      11'h7FF
`define CIPHER_SEED_FILL  6'h2A
`define CIPHER_SYNC_BITS  22
`define CIPHER_SYNC_W     5

`endif

/* File: line_coding_pkg.sv */
// Types and helper functions shared by the line coding modules
`include "tx_line_coding_defines.svh"
`default_nettype none

package line_coding_pkg;

	typedef enum logic [1:0] {
		LVL_ZERO  = 2'h0,
		LVL_PLUS  = 2'h1,
		LVL_MINUS = 2'h2
	} mlt_level_t;

	// Gray-coded position in the 0, +1, 0, -1 cycle
	typedef enum logic [1:0] {
		PH_ZERO_UP   = 2'h0,
		PH_PLUS      = 2'h1,
		PH_ZERO_DOWN = 2'h3,
		PH_MINUS     = 2'h2
	} mlt_phase_t;

	function automatic logic cipher_fb(input logic [`CIPHER_W-1:0] sr);
		return sr[`CIPHER_TAP_A] ^ sr[`CIPHER_TAP_B];
	endfunction

	function automatic mlt_phase_t mlt_step(input mlt_phase_t ph);
		case (ph)
			PH_ZERO_UP:   return PH_PLUS;
			PH_PLUS:      return PH_ZERO_DOWN;
			PH_ZERO_DOWN: return PH_MINUS;
			default:      return PH_ZERO_UP;
		endcase
	endfunction

	function automatic mlt_level_t mlt_level(input mlt_phase_t ph);
		case (ph)
			PH_PLUS:  return LVL_PLUS;
			PH_MINUS: return LVL_MINUS;
			default:  return LVL_ZERO;
		endcase
	endfunction

	function automatic mlt_level_t pins_level(input logic pos, input logic neg);
		if (pos && !neg) begin
			return LVL_PLUS;
		end else if (neg && !pos) begin
			return LVL_MINUS;
		end
		return LVL_ZERO;
	endfunction

endpackage

`default_nettype wire

/* File: cipher_if.sv */
// Control and key signals between the datapath and a cipher register
`include "tx_line_coding_defines.svh"
`default_nettype none

interface cipher_if;
	logic                 step;
	logic                 load;
	logic [`CIPHER_W-1:0] load_val;
	logic                 sync_sel;
	logic                 sync_bit;
	logic                 key;

	modport ctrl (output step, load, load_val, sync_sel, sync_bit, input key);
	modport lfsr (input step, load, load_val, sync_sel, sync_bit, output key);
endinterface

`default_nettype wire

/* File: cipher_lfsr.sv */
// Eleven-bit stream cipher register, free running or fed from the line
`include "tx_line_coding_defines.svh"
`default_nettype none

module cipher_lfsr
	import line_coding_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic nrst,
	cipher_if.lfsr    cif
);

	typedef struct packed {
		logic [`CIPHER_W-1:0] sr;
	} lfsr_st_t;

	lfsr_st_t st_reg;
	lfsr_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (cif.load) begin
			st_next.sr = cif.load_val;
		end else if (cif.step) begin
			st_next.sr = {st_reg.sr[`CIPHER_W-2:0], cif.sync_sel ? cif.sync_bit : cipher_fb(st_reg.sr)};
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '{sr: `CIPHER_RESET};
		end else begin
			st_reg <= st_next;
		end
	end

	assign cif.key = cipher_fb(st_reg.sr);

	property p_free_run_shift;
		@(posedge ref_clk) disable iff (!nrst)
		cif.step && !cif.load && !cif.sync_sel
			|=> st_reg.sr == {$past(st_reg.sr[`CIPHER_W-2:0]), $past(cif.key)};
	endproperty
	a_free_run_shift: assert property (p_free_run_shift)
		else $error("cipher register did not shift in its feedback");

endmodule

`default_nettype wire

/* File: tx_line_coding_100tx_10t.sv */
// Twisted-pair line coding datapath: cipher, NRZI, three-level and Manchester
`include "tx_line_coding_defines.svh"
`default_nettype none

module tx_line_coding_100tx_10t
	import line_coding_pkg::*;
#(
	parameter int CNT_W  = `MAN_CNT_W,
	parameter int SYNC_W = `CIPHER_SYNC_W
)(
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic                 speed_100,
	input  wire logic                 sym_mode,
	input  wire logic [`ADDR_W-1:0]   phy_addr,
	input  wire logic                 tx_ser_bit,
	input  wire logic                 tx_ser_valid,
	output var  logic                 rx_ser_bit,
	output var  logic                 rx_ser_valid,
	output var  logic                 cipher_locked,
	input  wire logic [`NIBBLE_W-1:0] tx_nibble,
	input  wire logic                 tx_nibble_valid,
	output var  logic                 tx_nibble_ready,
	output var  logic [`NIBBLE_W-1:0] rx_nibble,
	output var  logic                 rx_nibble_valid,
	output var  logic                 line_tx_pos,
	output var  logic                 line_tx_neg,
	input  wire logic                 line_rx_pos,
	input  wire logic                 line_rx_neg
);

	localparam logic [CNT_W-1:0]  HALF_LAST = CNT_W'(`MAN_HALF_CYC - 1);
	localparam logic [CNT_W-1:0]  EDGE_GAP  = CNT_W'(`MAN_EDGE_GAP_CYC);
	localparam logic [CNT_W-1:0]  IDLE_GAP  = CNT_W'(`MAN_IDLE_CYC);
	localparam logic [SYNC_W-1:0] SYNC_DONE = SYNC_W'(`CIPHER_SYNC_BITS);

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic                 rxp_meta;
		logic                 rxn_meta;
		logic                 rxp_s;
		logic                 rxn_s;
		logic                 spd_d;
		logic                 tx_nrzi;
		logic                 tx_vd;
		mlt_phase_t           phase;
		mlt_level_t           rx_lvl;
		logic                 rx_nrzi;
		logic                 rx_bit;
		logic                 rx_valid;
		logic [SYNC_W-1:0]    sync_cnt;
		logic                 locked;
		logic                 mtx_active;
		logic                 mtx_half;
		logic [1:0]           mtx_bitcnt;
		logic [`NIBBLE_W-1:0] mtx_sh;
		logic [CNT_W-1:0]     mtx_cnt;
		logic [CNT_W-1:0]     mrx_gap;
		logic                 mrx_pos;
		logic [1:0]           mrx_bitcnt;
		logic [`NIBBLE_W-1:0] mrx_sh;
		logic [`NIBBLE_W-1:0] mrx_nib;
		logic                 mrx_valid;
		logic                 out_pos;
		logic                 out_neg;
	} core_st_t;

	core_st_t   st_reg;
	core_st_t   st_next;
	logic       cipher_on;
	logic       tx_scr;
	mlt_level_t rx_lvl_now;
	logic       rx_nrzi_now;
	logic       rx_scr;
	logic       man_tick;
	logic       man_last;
	logic       man_accept;
	logic       mrx_mid;
	logic       mrx_bit;

	cipher_if tx_cif ();
	cipher_if rx_cif ();

	cipher_lfsr u_tx_cipher (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.cif     (tx_cif.lfsr)
	);

	cipher_lfsr u_rx_cipher (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.cif     (rx_cif.lfsr)
	);

	// ----------------------------------------------------------------------
	// Cipher control
	// ----------------------------------------------------------------------
	// symbol mode turns the cipher off
	assign cipher_on = speed_100 && !sym_mode;

	// seed on entry to 100M mode
	assign tx_cif.load     = speed_100 && !st_reg.spd_d;
	assign tx_cif.load_val = {`CIPHER_SEED_FILL, phy_addr};
	assign tx_cif.step     = cipher_on && tx_ser_valid;
	assign tx_cif.sync_sel = 1'b0;
	assign tx_cif.sync_bit = 1'b0;

	// receiver learns key from idle ones
	assign rx_cif.load     = 1'b0;
	assign rx_cif.load_val = '0;
	assign rx_cif.step     = cipher_on;
	assign rx_cif.sync_sel = !st_reg.locked;
	assign rx_cif.sync_bit = !rx_scr;

	// ----------------------------------------------------------------------
	// Combinational terms
	// ----------------------------------------------------------------------
	// key added to each transmitted bit while the cipher is on
	assign tx_scr = tx_ser_bit ^ (cipher_on && tx_cif.key);

	// level change marks an NRZI one
	assign rx_lvl_now  = pins_level(st_reg.rxp_s, st_reg.rxn_s);
	assign rx_nrzi_now = (rx_lvl_now != st_reg.rx_lvl);
	assign rx_scr      = rx_nrzi_now ^ st_reg.rx_nrzi;

	assign man_tick        = st_reg.mtx_active && (st_reg.mtx_cnt == HALF_LAST);
	assign man_last        = man_tick && st_reg.mtx_half && (st_reg.mtx_bitcnt == `NIB_LAST_BIT);
	assign tx_nibble_ready = !speed_100 && (!st_reg.mtx_active || man_last);
	assign man_accept      = tx_nibble_valid && tx_nibble_ready;

	// late edge is the mid-bit one
	assign mrx_mid = (st_reg.rxp_s != st_reg.mrx_pos) && (st_reg.mrx_gap >= EDGE_GAP);
	assign mrx_bit = !st_reg.rxp_s;

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		st_next          = st_reg;
		st_next.rxp_meta = line_rx_pos;
		st_next.rxn_meta = line_rx_neg;
		st_next.rxp_s    = st_reg.rxp_meta;
		st_next.rxn_s    = st_reg.rxn_meta;
		st_next.spd_d    = speed_100;

		st_next.tx_vd = speed_100 && tx_ser_valid;
		if (st_next.tx_vd) begin
			st_next.tx_nrzi = st_reg.tx_nrzi ^ tx_scr;
		end
		// step on one, hold on zero
		if (st_reg.tx_vd && st_reg.tx_nrzi) begin
			st_next.phase = mlt_step(st_reg.phase);
		end

		st_next.rx_lvl   = rx_lvl_now;
		st_next.rx_nrzi  = rx_nrzi_now;
		st_next.rx_valid = speed_100;
		st_next.rx_bit   = rx_scr ^ (cipher_on && rx_cif.key);

		// lock after a run of matches
		if (!cipher_on) begin
			st_next.sync_cnt = '0;
			st_next.locked   = 1'b0;
		end else if (!st_reg.locked) begin
			if (rx_cif.key == !rx_scr) begin
				st_next.sync_cnt = SYNC_W'(st_reg.sync_cnt + 1'b1);
				st_next.locked   = (st_reg.sync_cnt == SYNC_DONE);
			end else begin
				st_next.sync_cnt = '0;
			end
		end

		if (speed_100) begin
			st_next.mtx_active = 1'b0;
		end else if (man_accept) begin
			st_next.mtx_active = 1'b1;
			st_next.mtx_half   = 1'b0;
			st_next.mtx_bitcnt = '0;
			st_next.mtx_sh     = tx_nibble;
			st_next.mtx_cnt    = '0;
		end else if (man_tick) begin
			st_next.mtx_cnt = '0;
			if (!st_reg.mtx_half) begin
				st_next.mtx_half = 1'b1;
			end else begin
				st_next.mtx_half   = 1'b0;
				st_next.mtx_sh     = st_reg.mtx_sh >> 1;
				st_next.mtx_bitcnt = 2'(st_reg.mtx_bitcnt + 1'b1);
				st_next.mtx_active = (st_reg.mtx_bitcnt != `NIB_LAST_BIT);
			end
		end else if (st_reg.mtx_active) begin
			st_next.mtx_cnt = CNT_W'(st_reg.mtx_cnt + 1'b1);
		end

		st_next.mrx_valid = 1'b0;
		st_next.mrx_pos   = st_reg.rxp_s;
		if (speed_100) begin
			st_next.mrx_gap    = '0;
			st_next.mrx_bitcnt = '0;
		end else if (mrx_mid) begin
			st_next.mrx_gap    = '0;
			st_next.mrx_sh     = {mrx_bit, st_reg.mrx_sh[`NIBBLE_W-1:1]};
			st_next.mrx_bitcnt = 2'(st_reg.mrx_bitcnt + 1'b1);
			if (st_reg.mrx_bitcnt == `NIB_LAST_BIT) begin
				st_next.mrx_nib   = {mrx_bit, st_reg.mrx_sh[`NIBBLE_W-1:1]};
				st_next.mrx_valid = 1'b1;
			end
		end else if (st_reg.mrx_gap != IDLE_GAP) begin
			st_next.mrx_gap = CNT_W'(st_reg.mrx_gap + 1'b1);
		end else begin
			st_next.mrx_bitcnt = '0;
		end

		// one pin pair, coding by speed
		if (speed_100) begin
			st_next.out_pos = (mlt_level(st_next.phase) == LVL_PLUS);
			st_next.out_neg = (mlt_level(st_next.phase) == LVL_MINUS);
		end else begin
			st_next.out_pos = st_next.mtx_active && (st_next.mtx_sh[0] ^ st_next.mtx_half);
			st_next.out_neg = st_next.mtx_active && !(st_next.mtx_sh[0] ^ st_next.mtx_half);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	assign line_tx_pos     = st_reg.out_pos;
	assign line_tx_neg     = st_reg.out_neg;
	assign rx_ser_bit      = st_reg.rx_bit;
	assign rx_ser_valid    = st_reg.rx_valid;
	assign cipher_locked   = st_reg.locked;
	assign rx_nibble       = st_reg.mrx_nib;
	assign rx_nibble_valid = st_reg.mrx_valid;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_nrzi_one;
		speed_100 && tx_ser_valid ##1 st_reg.tx_nrzi;
	endsequence

	sequence s_man_one_first;
		!speed_100 && st_reg.mtx_active && !st_reg.mtx_half && st_reg.mtx_sh[0] && man_tick;
	endsequence

	// key and bit both reach NRZI
	property p_scramble_bit;
		cipher_on && tx_ser_valid && !tx_cif.load
			|=> st_reg.tx_nrzi == ($past(st_reg.tx_nrzi) ^ $past(tx_ser_bit) ^ $past(tx_cif.key));
	endproperty
	a_scramble_bit: assert property (p_scramble_bit)
		else $error("transmit bit not scrambled with key");

	property p_seed_from_addr;
		speed_100 && !st_reg.spd_d |=> tx_cif.key == cipher_fb({`CIPHER_SEED_FILL, $past(phy_addr)});
	endproperty
	a_seed_from_addr: assert property (p_seed_from_addr)
		else $error("transmit cipher not seeded from address");

	property p_symbol_bypass;
		speed_100 && sym_mode && tx_ser_valid
			|=> st_reg.tx_nrzi == ($past(st_reg.tx_nrzi) ^ $past(tx_ser_bit));
	endproperty
	a_symbol_bypass: assert property (p_symbol_bypass)
		else $error("symbol mode bit was ciphered");

	property p_mlt_step;
		s_nrzi_one |=> st_reg.phase == mlt_step($past(st_reg.phase));
	endproperty
	a_mlt_step: assert property (p_mlt_step)
		else $error("three-level encoder did not step on one");

	property p_nrzi_hold;
		speed_100 && tx_ser_valid && !tx_scr |=> $stable(st_reg.tx_nrzi)
			##1 st_reg.phase == ($past(st_reg.tx_nrzi) ? mlt_step($past(st_reg.phase)) : $past(st_reg.phase));
	endproperty
	a_nrzi_hold: assert property (p_nrzi_hold)
		else $error("NRZI or level changed on a zero");

	property p_mlt_pins;
		speed_100 [*2] |-> line_tx_pos == (mlt_level(st_reg.phase) == LVL_PLUS)
			&& line_tx_neg == (mlt_level(st_reg.phase) == LVL_MINUS);
	endproperty
	a_mlt_pins: assert property (p_mlt_pins)
		else $error("transmit pins disagree with three-level state");

	property p_man_one;
		s_man_one_first |-> line_tx_pos && !line_tx_neg ##1 !line_tx_pos && line_tx_neg;
	endproperty
	a_man_one: assert property (p_man_one)
		else $error("Manchester one has wrong half levels");

	property p_nibble_load;
		man_accept |=> st_reg.mtx_active && st_reg.mtx_sh == $past(tx_nibble) && st_reg.mtx_bitcnt == 2'h0;
	endproperty
	a_nibble_load: assert property (p_nibble_load)
		else $error("accepted nibble not loaded");

	// nibble out after fourth mid-bit edge
	property p_rx_nibble;
		rx_nibble_valid |-> $past(mrx_mid) && $past(st_reg.mrx_bitcnt) == `NIB_LAST_BIT
			&& rx_nibble[`NIBBLE_W-1] == $past(mrx_bit);
	endproperty
	a_rx_nibble: assert property (p_rx_nibble)
		else $error("receive nibble without four decoded bits");

	// bypassed receive bit is the NRZI decode
	property p_rx_nrzi;
		speed_100 && sym_mode |=> rx_ser_valid && rx_ser_bit == ($past(rx_nrzi_now) ^ $past(st_reg.rx_nrzi));
	endproperty
	a_rx_nrzi: assert property (p_rx_nrzi)
		else $error("three-level receive not decoded to NRZI");

	property p_ten_mode_line;
		!speed_100 [*2] |-> !rx_ser_valid && ((line_tx_pos ^ line_tx_neg) == st_reg.mtx_active);
	endproperty
	a_ten_mode_line: assert property (p_ten_mode_line)
		else $error("10M line not two-level Manchester");

endmodule

`default_nettype wire

/* File: line_partner.sv */
// Remote link partner model: cable looped back to the receive pair
`default_nettype none

module line_partner (
	input  wire logic ref_clk,
	input  wire logic tx_pos,
	input  wire logic tx_neg,
	output var  logic rx_pos = 1'b0,
	output var  logic rx_neg = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------------
	// Cable delay of one cycle
	// ----------------------------------------------------------------------
	// shared receive pair
	always @(posedge ref_clk) begin
		rx_pos <= tx_pos;
		rx_neg <= tx_neg;
	end

endmodule

`default_nettype wire

/* File: tx_line_coding_100tx_10t_test.sv */
// Self-checking bench for the twisted-pair line coding block
`include "tx_line_coding_defines.svh"
`default_nettype none

module tx_line_coding_100tx_10t_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------------
	// Signals and scoreboard
	// ----------------------------------------------------------------------
	logic                 ref_clk         = 1'b0;
	logic                 nrst            = 1'b0;
	logic                 speed_100       = 1'b0;
	logic                 sym_mode        = 1'b0;
	logic [`ADDR_W-1:0]   phy_addr        = 5'h00;
	logic                 tx_ser_bit      = 1'b0;
	logic                 tx_ser_valid    = 1'b0;
	logic [`NIBBLE_W-1:0] tx_nibble       = 4'h0;
	logic                 tx_nibble_valid = 1'b0;
	logic                 rx_ser_bit;
	logic                 rx_ser_valid;
	logic                 cipher_locked;
	logic                 tx_nibble_ready;
	logic [`NIBBLE_W-1:0] rx_nibble;
	logic                 rx_nibble_valid;
	logic                 line_tx_pos;
	logic                 line_tx_neg;
	logic                 line_rx_pos;
	logic                 line_rx_neg;
	logic [31:0]          seed            = 32'h55E6452F;
	int                   errors          = 0;
	int                   compares        = 0;
	int                   cycles          = 0;
	logic [1:0]           act_lvl[$];
	logic [1:0]           exp_lvl[$];
	logic [1:0]           act_rx[$];
	logic [1:0]           exp_rx[$];
	logic [3:0]           act_nib[$];
	logic [3:0]           exp_nib[$];

	tx_line_coding_100tx_10t i_dut (
		.ref_clk         (ref_clk),
		.nrst            (nrst),
		.speed_100       (speed_100),
		.sym_mode        (sym_mode),
		.phy_addr        (phy_addr),
		.tx_ser_bit      (tx_ser_bit),
		.tx_ser_valid    (tx_ser_valid),
		.rx_ser_bit      (rx_ser_bit),
		.rx_ser_valid    (rx_ser_valid),
		.cipher_locked   (cipher_locked),
		.tx_nibble       (tx_nibble),
		.tx_nibble_valid (tx_nibble_valid),
		.tx_nibble_ready (tx_nibble_ready),
		.rx_nibble       (rx_nibble),
		.rx_nibble_valid (rx_nibble_valid),
		.line_tx_pos     (line_tx_pos),
		.line_tx_neg     (line_tx_neg),
		.line_rx_pos     (line_rx_pos),
		.line_rx_neg     (line_rx_neg)
	);

	line_partner i_partner (
		.ref_clk (ref_clk),
		.tx_pos  (line_tx_pos),
		.tx_neg  (line_tx_neg),
		.rx_pos  (line_rx_pos),
		.rx_neg  (line_rx_neg)
	);

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------------
	// Monitor and hang guard
	// ----------------------------------------------------------------------
	always @(posedge ref_clk) begin
		act_lvl.push_back({line_tx_pos, line_tx_neg});
		if (rx_ser_valid) begin
			act_rx.push_back({1'b0, rx_ser_bit});
		end
		if (rx_nibble_valid) begin
			act_nib.push_back(rx_nibble);
		end
		cycles++;
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Pin pair for a position in the 0, +1, 0, -1 cycle
	function automatic logic [1:0] lvl(input logic [1:0] p);
		return (p == 2'h1) ? 2'b10 : ((p == 2'h3) ? 2'b01 : 2'b00);
	endfunction

	// Whether e occurs in a at any offset
	function automatic logic contains(input logic [1:0] a[$], input logic [1:0] e[$]);
		logic ok;
		for (int k = 0; k + e.size() <= a.size(); k++) begin
			ok = 1'b1;
			for (int i = 0; i < e.size(); i++) begin
				if (a[k + i] !== e[i]) begin
					ok = 1'b0;
				end
			end
			if (ok) begin
				return 1'b1;
			end
		end
		return 1'b0;
	endfunction

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic spd, input logic sym);
		nrst <= 1'b0;
		speed_100 <= spd;
		sym_mode <= sym;
		tx_ser_valid <= 1'b0;
		tx_nibble_valid <= 1'b0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		act_lvl.delete();
		exp_lvl.delete();
		act_rx.delete();
		exp_rx.delete();
		act_nib.delete();
		exp_nib.delete();
	endtask

	// ----------------------------------------------------------------------
	// 100M: idle ones for lock, n random bits, idle tail
	// ----------------------------------------------------------------------
	task automatic run100(input logic sym, input int n);
		logic [31:0] r;
		logic [10:0] sr;
		logic        b;
		logic        k;
		logic        nrzi;
		logic [1:0]  ph;
		r = rnd();
		phy_addr <= r[`ADDR_W-1:0];
		do_reset(1'b1, sym);
		sr = {`CIPHER_SEED_FILL, phy_addr};
		nrzi = 1'b0;
		ph = 2'h0;
		for (int i = 0; i < n + 58; i++) begin
			r = rnd();
			b = (i < 48 || i >= n + 48) ? 1'b1 : r[0];
			if (i >= 48 && i < n + 48) begin
				exp_rx.push_back({1'b0, b});
			end
			k = sym ? 1'b0 : (sr[10] ^ sr[8]);
			sr = {sr[9:0], sr[10] ^ sr[8]};
			nrzi = nrzi ^ b ^ k;
			if (nrzi) begin
				ph = ph + 2'h1;
			end
			exp_lvl.push_back(lvl(ph));
			tx_ser_bit <= b;
			tx_ser_valid <= 1'b1;
			@(posedge ref_clk);
		end
		tx_ser_valid <= 1'b0;
		// Let the last levels reach the pins and the monitor
		repeat (4) @(posedge ref_clk);
		check(4'(contains(act_lvl, exp_lvl)), 4'h1);
		check(4'(contains(act_rx, exp_rx)), 4'h1);
		check(4'(tx_nibble_ready), 4'h0);
		if (!sym) begin
			check(4'(cipher_locked), 4'h1);
		end
	endtask

	// ----------------------------------------------------------------------
	// 10M: n nibbles back to back, first starts with a zero bit
	// ----------------------------------------------------------------------
	task automatic run10(input int n);
		logic [31:0] r;
		logic [3:0]  nib;
		do_reset(1'b0, 1'b0);
		check(4'(tx_nibble_ready), 4'h1);
		exp_lvl.push_back(2'b00);
		for (int i = 0; i < n; i++) begin
			r = rnd();
			nib = (i == 0) ? 4'hA : r[3:0];
			exp_nib.push_back(nib);
			for (int j = 0; j < 4; j++) begin
				for (int h = 0; h < 10; h++) begin
					exp_lvl.push_back((nib[j] ^ (h >= 5)) ? 2'b10 : 2'b01);
				end
			end
			tx_nibble <= nib;
			tx_nibble_valid <= 1'b1;
			for (int w = 0; w < 60; w++) begin
				@(posedge ref_clk);
				if (tx_nibble_ready) begin
					break;
				end
			end
		end
		tx_nibble_valid <= 1'b0;
		exp_lvl.push_back(2'b00);
		repeat (80) @(posedge ref_clk);
		check(4'(contains(act_lvl, exp_lvl)), 4'h1);
		check(4'(act_nib.size() >= n), 4'h1);
		for (int i = 0; i < n && i < act_nib.size(); i++) begin
			check(act_nib[i], exp_nib[i]);
		end
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		for (int i = 0; i < 3; i++) begin
			run100(1'b0, 64);
		end
		run100(1'b1, 64);
		run10(6);
		run10(6);
		conclude();
	end

endmodule

`default_nettype wire
